// file: shared/oad_pkg.sv
// Shared constants and types for the operand addressing decoder
`default_nettype none
package oad_pkg;

  // Addressing form codes
  localparam logic [1:0] OAD_MOD_NODISP = 2'h0;
  localparam logic [1:0] OAD_MOD_DISP8 = 2'h1;
  localparam logic [1:0] OAD_MOD_DISP16 = 2'h2;
  localparam logic [1:0] OAD_MOD_REG = 2'h3;

  // Operand select codes
  localparam logic [2:0] OAD_RM_BW_SI = 3'h0;
  localparam logic [2:0] OAD_RM_BW_DI = 3'h1;
  localparam logic [2:0] OAD_RM_BP_SI = 3'h2;
  localparam logic [2:0] OAD_RM_BP_DI = 3'h3;
  localparam logic [2:0] OAD_RM_SI = 3'h4;
  localparam logic [2:0] OAD_RM_DI = 3'h5;
  localparam logic [2:0] OAD_RM_BP = 3'h6;
  localparam logic [2:0] OAD_RM_DIRECT = 3'h6;

  // Segment override prefix fixed bits, around the 2-bit field
  localparam logic [2:0] OAD_PFX_HI = 3'h1;
  localparam logic [2:0] OAD_PFX_LO = 3'h6;

  // Flag word bit positions; other bits read zero
  localparam int OAD_FB_CARRY = 0;
  localparam int OAD_FB_PARITY = 2;
  localparam int OAD_FB_AUX = 4;
  localparam int OAD_FB_ZERO = 6;
  localparam int OAD_FB_SIGN = 7;
  localparam int OAD_FB_TRAP = 8;
  localparam int OAD_FB_INTEN = 9;
  localparam int OAD_FB_DIR = 10;
  localparam int OAD_FB_OVF = 11;

  // Fixed values
  localparam logic [7:0] OAD_SHIFT_ONE = 8'h01;
  localparam logic [15:0] OAD_ZERO_WORD = 16'h0000;

  // Register identities: words first, then low bytes, then high bytes
  typedef enum logic [3:0] {
    OAD_R_ACCUM_W, OAD_R_COUNT_W, OAD_R_DATA_W, OAD_R_BASE_W,
    OAD_R_STACK_PTR, OAD_R_BASE_PTR, OAD_R_SRC_IDX, OAD_R_DEST_IDX,
    OAD_R_ACCUM_LO, OAD_R_COUNT_LO, OAD_R_DATA_LO, OAD_R_BASE_LO,
    OAD_R_ACCUM_HI, OAD_R_COUNT_HI, OAD_R_DATA_HI, OAD_R_BASE_HI
  } oad_gpr_t;

  // Segment identities in field order 00..11
  typedef enum logic [1:0] {
    OAD_SEG_EXTRA, OAD_SEG_CODE, OAD_SEG_STACK, OAD_SEG_DATA
  } oad_seg_t;

endpackage
`default_nettype wire

// file: shared/oad_sel_if.sv
// Register select carrier between decoder and code mapper
`timescale 1ns/100ps
`default_nettype none
interface oad_sel_if;
  import oad_pkg::*;
  logic [2:0] code;
  logic word;
  oad_gpr_t id;
  modport mapper (input code, input word, output id);
  modport user (output code, output word, input id);
endinterface
`default_nettype wire

// file: src/oad_gpr_map.sv
// Maps a 3-bit register code and size bit to a register identity
`timescale 1ns/100ps
`default_nettype none
module oad_gpr_map (
  // Select carrier
  oad_sel_if.mapper sel
);
  import oad_pkg::*;

  // Enum order is words then bytes, so the size bit picks the half
  always_comb begin
    sel.id = oad_gpr_t'({~sel.word, sel.code});
  end

endmodule // oad_gpr_map
`default_nettype wire

// file: src/oad_decoder.sv
// Operand addressing decoder: byte sequencer and operand resolution
`timescale 1ns/100ps
`default_nettype none
module oad_decoder (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Instruction byte stream from fetch
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  // Opcode class, presented with the opcode byte
  input wire logic op_need_modrm,
  input wire logic op_need_imm,
  input wire logic op_has_sext,
  input wire logic op_is_shift,
  input wire logic op_is_str_cmp,
  input wire logic repeat_match_bit,
  // Datapath register values
  input wire logic [15:0] base_word_reg,
  input wire logic [15:0] base_pointer,
  input wire logic [15:0] source_index,
  input wire logic [15:0] dest_index,
  input wire logic [7:0] count_low_byte,
  // Datapath flags
  input wire logic overflow_flag,
  input wire logic direction_flag,
  input wire logic int_enable_flag,
  input wire logic trap_flag,
  input wire logic sign_flag,
  input wire logic zero_flag,
  input wire logic aux_carry_flag,
  input wire logic parity_flag,
  input wire logic carry_flag,
  // Decoded controls
  output logic decode_valid,
  output logic to_reg_dest,
  output logic word_op,
  output logic rm_is_reg,
  output oad_pkg::oad_gpr_t reg_operand,
  output oad_pkg::oad_gpr_t rm_operand,
  output logic [15:0] offset_value,
  output logic [15:0] effective_address,
  output logic [15:0] imm_operand,
  output logic [7:0] shift_count,
  output logic rep_continue,
  output logic seg_override,
  output oad_pkg::oad_seg_t seg_select,
  output logic [15:0] flags_word,
  output logic cond_above,
  output logic cond_below,
  output logic cond_greater,
  output logic cond_less
);
  import oad_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODRM, ST_DISP_LO, ST_DISP_HI,
    ST_IMM_LO, ST_IMM_HI, ST_FINISH
  } oad_st_t;

  typedef struct packed {
    oad_st_t st;
    logic dbit;
    logic wbit;
    logic sbit;
    logic need_imm;
    logic vbit;
    logic str_cmp;
    logic zbit;
    logic [1:0] mod;
    logic [2:0] regf;
    logic [2:0] rm;
    logic [7:0] disp_lo;
    logic [7:0] disp_hi;
    logic [7:0] imm_lo;
    logic [7:0] imm_hi;
    logic ovr;
    logic [1:0] seg;
    logic pfx_seen;
    logic [1:0] pfx_seg;
    logic ready;
    logic valid;
    logic to_reg;
    logic word;
    logic rm_reg;
    oad_gpr_t reg_id;
    oad_gpr_t rm_id;
    logic [15:0] offs;
    logic [15:0] ea;
    logic [15:0] imm;
    logic [7:0] shcnt;
    logic rep_go;
    logic [15:0] flw;
    logic above;
    logic below;
    logic greater;
    logic less;
  } oad_state_t;

  oad_state_t r_reg;
  oad_state_t r_next;
  logic take;
  logic is_prefix;
  logic [15:0] disp_word;
  logic [15:0] disp_sext;
  logic [15:0] offs_c;

  oad_sel_if reg_sel ();
  oad_sel_if rm_sel ();

  // Two mappers: one for the register field, one for a register operand
  oad_gpr_map u_map_reg (.sel(reg_sel.mapper));
  oad_gpr_map u_map_rm (.sel(rm_sel.mapper));

  // Register codes are resolved with the instruction's size bit
  assign reg_sel.code = r_reg.regf;
  assign reg_sel.word = r_reg.wbit;
  assign rm_sel.code = r_reg.rm;
  assign rm_sel.word = r_reg.wbit;

  // A byte is consumed only while enabled, offered and accepted
  assign take = clk_en & byte_valid & r_reg.ready;
  assign is_prefix = (byte_data[7:5] == OAD_PFX_HI) &&
                     (byte_data[2:0] == OAD_PFX_LO);
  assign disp_word = {r_reg.disp_hi, r_reg.disp_lo};
  assign disp_sext = {{8{r_reg.disp_lo[7]}}, r_reg.disp_lo};

  // Offset by addressing form
  always_comb begin
    case (r_reg.mod)
      OAD_MOD_DISP8: offs_c = disp_sext;
      OAD_MOD_DISP16: offs_c = disp_word;
      default: offs_c = OAD_ZERO_WORD;
    endcase
  end

  // Byte sequencer and result computation
  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    case (r_reg.st)
      ST_OPCODE: begin
        if (take && is_prefix) begin
          // Prefix only records the segment; opcode still to come
          r_next.pfx_seen = 1'b1;
          r_next.pfx_seg = byte_data[4:3];
        end else if (take) begin
          r_next.dbit = byte_data[1];
          r_next.wbit = byte_data[0];
          r_next.sbit = op_has_sext & byte_data[1];
          r_next.vbit = op_is_shift & byte_data[1];
          r_next.need_imm = op_need_imm;
          r_next.str_cmp = op_is_str_cmp;
          r_next.zbit = repeat_match_bit;
          r_next.mod = OAD_MOD_NODISP;
          r_next.regf = 3'h0;
          r_next.rm = 3'h0;
          r_next.disp_lo = 8'h00;
          r_next.disp_hi = 8'h00;
          r_next.imm_lo = 8'h00;
          r_next.imm_hi = 8'h00;
          if (op_need_modrm) begin
            r_next.st = ST_MODRM;
          end else if (op_need_imm) begin
            r_next.st = ST_IMM_LO;
          end else begin
            r_next.st = ST_FINISH;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          r_next.mod = byte_data[7:6];
          r_next.regf = byte_data[5:3];
          r_next.rm = byte_data[2:0];
          // Displacement comes straight after this second byte
          if (byte_data[7:6] == OAD_MOD_DISP8 ||
              byte_data[7:6] == OAD_MOD_DISP16 ||
              (byte_data[7:6] == OAD_MOD_NODISP &&
               byte_data[2:0] == OAD_RM_DIRECT)) begin
            r_next.st = ST_DISP_LO;
          end else if (r_reg.need_imm) begin
            r_next.st = ST_IMM_LO;
          end else begin
            r_next.st = ST_FINISH;
          end
        end
      end
      ST_DISP_LO: begin
        if (take) begin
          r_next.disp_lo = byte_data;
          if (r_reg.mod == OAD_MOD_DISP8) begin
            // Single byte form: no high byte follows
            r_next.st = r_reg.need_imm ? ST_IMM_LO : ST_FINISH;
          end else begin
            r_next.st = ST_DISP_HI;
          end
        end
      end
      ST_DISP_HI: begin
        if (take) begin
          r_next.disp_hi = byte_data;
          r_next.st = r_reg.need_imm ? ST_IMM_LO : ST_FINISH;
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          r_next.imm_lo = byte_data;
          if (r_reg.wbit && !r_reg.sbit) begin
            r_next.st = ST_IMM_HI;
          end else begin
            r_next.st = ST_FINISH;
          end
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          r_next.imm_hi = byte_data;
          r_next.st = ST_FINISH;
        end
      end
      ST_FINISH: begin
        r_next.valid = 1'b1;
        r_next.to_reg = r_reg.dbit;
        r_next.word = r_reg.wbit;
        r_next.rm_reg = (r_reg.mod == OAD_MOD_REG);
        r_next.reg_id = reg_sel.id;
        r_next.rm_id = rm_sel.id;
        r_next.offs = offs_c;
        // Sums are 16 bits wide, so carries out of bit 15 are dropped
        if (r_reg.mod == OAD_MOD_NODISP && r_reg.rm == OAD_RM_DIRECT) begin
          r_next.ea = disp_word;
        end else if (r_reg.rm == OAD_RM_BW_SI) begin
          r_next.ea = base_word_reg + source_index + offs_c;
        end else if (r_reg.rm == OAD_RM_BW_DI) begin
          r_next.ea = base_word_reg + dest_index + offs_c;
        end else if (r_reg.rm == OAD_RM_BP_SI) begin
          r_next.ea = base_pointer + source_index + offs_c;
        end else if (r_reg.rm == OAD_RM_BP_DI) begin
          r_next.ea = base_pointer + dest_index + offs_c;
        end else if (r_reg.rm == OAD_RM_SI) begin
          r_next.ea = source_index + offs_c;
        end else if (r_reg.rm == OAD_RM_DI) begin
          r_next.ea = dest_index + offs_c;
        end else if (r_reg.rm == OAD_RM_BP) begin
          r_next.ea = base_pointer + offs_c;
        end else begin
          r_next.ea = base_word_reg + offs_c;
        end
        // Immediate: byte, sign-extended byte or full word
        if (!r_reg.wbit) begin
          r_next.imm = {8'h00, r_reg.imm_lo};
        end else if (r_reg.sbit) begin
          r_next.imm = {{8{r_reg.imm_lo[7]}}, r_reg.imm_lo};
        end else begin
          r_next.imm = {r_reg.imm_hi, r_reg.imm_lo};
        end
        r_next.shcnt = r_reg.vbit ? count_low_byte : OAD_SHIFT_ONE;
        // Non-comparing primitives never stop on the zero flag
        r_next.rep_go = r_reg.str_cmp ?
                        (zero_flag == r_reg.zbit) : 1'b1;
        r_next.flw = OAD_ZERO_WORD;
        r_next.flw[OAD_FB_CARRY] = carry_flag;
        r_next.flw[OAD_FB_PARITY] = parity_flag;
        r_next.flw[OAD_FB_AUX] = aux_carry_flag;
        r_next.flw[OAD_FB_ZERO] = zero_flag;
        r_next.flw[OAD_FB_SIGN] = sign_flag;
        r_next.flw[OAD_FB_TRAP] = trap_flag;
        r_next.flw[OAD_FB_INTEN] = int_enable_flag;
        r_next.flw[OAD_FB_DIR] = direction_flag;
        r_next.flw[OAD_FB_OVF] = overflow_flag;
        r_next.above = ~carry_flag & ~zero_flag;
        r_next.below = carry_flag;
        r_next.greater = ~(sign_flag ^ overflow_flag) & ~zero_flag;
        r_next.less = sign_flag ^ overflow_flag;
        // Report the prefix with this result, then forget it so the
        // next instruction starts without an override
        r_next.ovr = r_reg.pfx_seen;
        r_next.seg = r_reg.pfx_seg;
        r_next.pfx_seen = 1'b0;
        r_next.st = ST_OPCODE;
      end
      default: r_next.st = ST_OPCODE;
    endcase
    // Stall fetch for the single finish cycle before the result
    r_next.ready = (r_next.st != ST_FINISH);
  end

  // State register; ready is low for the first cycle after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign byte_ready = r_reg.ready;
  assign decode_valid = r_reg.valid;
  assign to_reg_dest = r_reg.to_reg;
  assign word_op = r_reg.word;
  assign rm_is_reg = r_reg.rm_reg;
  assign reg_operand = r_reg.reg_id;
  assign rm_operand = r_reg.rm_id;
  assign offset_value = r_reg.offs;
  assign effective_address = r_reg.ea;
  assign imm_operand = r_reg.imm;
  assign shift_count = r_reg.shcnt;
  assign rep_continue = r_reg.rep_go;
  assign seg_override = r_reg.ovr;
  assign seg_select = oad_seg_t'(r_reg.seg);
  assign flags_word = r_reg.flw;
  assign cond_above = r_reg.above;
  assign cond_below = r_reg.below;
  assign cond_greater = r_reg.greater;
  assign cond_less = r_reg.less;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_dir;
    decode_valid |-> to_reg_dest == r_reg.dbit;
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit lost");

  property p_size;
    decode_valid |-> word_op == r_reg.wbit;
  endproperty
  a_size: assert property (p_size) else $error("size bit lost");

  property p_regform;
    decode_valid |-> rm_is_reg == (r_reg.mod == OAD_MOD_REG);
  endproperty
  a_regform: assert property (p_regform) else $error("register form");

  property p_nodisp;
    decode_valid && r_reg.mod == OAD_MOD_NODISP |-> offset_value == 16'h0000;
  endproperty
  a_nodisp: assert property (p_nodisp) else $error("offset not zero");

  property p_disp8;
    decode_valid && r_reg.mod == OAD_MOD_DISP8 |->
      offset_value == {{8{r_reg.disp_lo[7]}}, r_reg.disp_lo};
  endproperty
  a_disp8: assert property (p_disp8) else $error("short offset");

  property p_disp16;
    decode_valid && r_reg.mod == OAD_MOD_DISP16 |->
      offset_value == {r_reg.disp_hi, r_reg.disp_lo};
  endproperty
  a_disp16: assert property (p_disp16) else $error("long offset");

  property p_direct;
    decode_valid && r_reg.mod == OAD_MOD_NODISP && r_reg.rm == 3'h6 |->
      effective_address == {r_reg.disp_hi, r_reg.disp_lo};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address");

  property p_disp_order;
    take && r_reg.st == ST_MODRM && byte_data[7:6] == OAD_MOD_DISP16 |=>
      r_reg.st == ST_DISP_LO;
  endproperty
  a_disp_order: assert property (p_disp_order) else $error("disp order");

  property p_imm_sext;
    decode_valid && r_reg.wbit && r_reg.sbit |->
      imm_operand == {{8{r_reg.imm_lo[7]}}, r_reg.imm_lo};
  endproperty
  a_imm_sext: assert property (p_imm_sext) else $error("imm extend");

  property p_shift;
    decode_valid && !r_reg.vbit |-> shift_count == 8'h01;
  endproperty
  a_shift: assert property (p_shift) else $error("shift count");

  property p_finish;
    clk_en && r_reg.st == ST_FINISH |=> decode_valid && byte_ready &&
      seg_override == $past(r_reg.pfx_seen) && !r_reg.pfx_seen;
  endproperty
  a_finish: assert property (p_finish) else $error("finish cycle");

endmodule // oad_decoder
`default_nettype wire

// file: verif/oad_fetch_model.sv
// Fetch queue model that offers instruction bytes to the decoder
`timescale 1ns/100ps
`default_nettype none
module oad_fetch_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Byte handshake
  input wire logic clk_en,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q [$];
  logic [7:0] last;
  logic slow;
  logic taken;

  initial slow = 1'b0;

  // Queue one byte in fetch order
  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask

  // Hold an offered byte until taken; an idle line shows the inverse of
  // the last byte so a stale value can never pass for fresh data
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_valid <= 1'b0;
      byte_data <= 8'hff;
      last = 8'h00;
    end else begin
      taken = byte_valid && byte_ready && clk_en;
      if (taken) begin
        last = q.pop_front();
      end
      // Slow mode leaves one idle cycle after every byte taken
      if (!byte_valid || taken) begin
        if (q.size() != 0 && !(slow && taken)) begin
          byte_valid <= 1'b1;
          byte_data <= q[0];
        end else begin
          byte_valid <= 1'b0;
          byte_data <= ~last;
        end
      end
    end
  end
endmodule // oad_fetch_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the operand addressing decoder
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  import oad_pkg::*;
  logic sys_clk, rst, clk_en, byte_valid, byte_ready, decode_valid;
  logic [7:0] byte_data, count_low_byte, shift_count;
  logic op_need_modrm, op_need_imm, op_has_sext, op_is_shift;
  logic op_is_str_cmp, repeat_match_bit;
  logic [15:0] base_word_reg, base_pointer, source_index, dest_index;
  logic overflow_flag, direction_flag, int_enable_flag, trap_flag;
  logic sign_flag, zero_flag, aux_carry_flag, parity_flag, carry_flag;
  logic to_reg_dest, word_op, rm_is_reg, rep_continue, seg_override;
  oad_gpr_t reg_operand, rm_operand;
  oad_seg_t seg_select;
  logic [15:0] offset_value, effective_address, imm_operand, flags_word;
  logic cond_above, cond_below, cond_greater, cond_less;
  int bad_count, checks_done, hold;
  logic [7:0] bq [$];
  logic [8:0] f;
  localparam logic [8:0] FP [4] = '{9'h1ff, 9'h155, 9'h0aa, 9'h010};

  oad_decoder dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .op_need_modrm(op_need_modrm),
    .op_need_imm(op_need_imm), .op_has_sext(op_has_sext),
    .op_is_shift(op_is_shift), .op_is_str_cmp(op_is_str_cmp),
    .repeat_match_bit(repeat_match_bit), .base_word_reg(base_word_reg),
    .base_pointer(base_pointer), .source_index(source_index),
    .dest_index(dest_index), .count_low_byte(count_low_byte),
    .overflow_flag(overflow_flag), .direction_flag(direction_flag),
    .int_enable_flag(int_enable_flag), .trap_flag(trap_flag),
    .sign_flag(sign_flag), .zero_flag(zero_flag),
    .aux_carry_flag(aux_carry_flag), .parity_flag(parity_flag),
    .carry_flag(carry_flag), .decode_valid(decode_valid),
    .to_reg_dest(to_reg_dest), .word_op(word_op), .rm_is_reg(rm_is_reg),
    .reg_operand(reg_operand), .rm_operand(rm_operand),
    .offset_value(offset_value), .effective_address(effective_address),
    .imm_operand(imm_operand), .shift_count(shift_count),
    .rep_continue(rep_continue), .seg_override(seg_override),
    .seg_select(seg_select), .flags_word(flags_word),
    .cond_above(cond_above), .cond_below(cond_below),
    .cond_greater(cond_greater), .cond_less(cond_less));
  oad_fetch_model fm (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data));

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Address sum expected for each operand select code
  function automatic logic [15:0] ea_of(input logic [2:0] rm,
                                        input logic [15:0] d);
    case (rm)
      3'h0: ea_of = base_word_reg + source_index + d;
      3'h1: ea_of = base_word_reg + dest_index + d;
      3'h2: ea_of = base_pointer + source_index + d;
      3'h3: ea_of = base_pointer + dest_index + d;
      3'h4: ea_of = source_index + d;
      3'h5: ea_of = dest_index + d;
      3'h6: ea_of = base_pointer + d;
      default: ea_of = base_word_reg + d;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Set the opcode class, queue the bytes, wait for the result pulse;
  // bytes go in at the falling edge so the model never races the push
  task automatic run(input logic [4:0] c);
    @(posedge sys_clk);
    {op_need_modrm, op_need_imm, op_has_sext, op_is_shift,
     op_is_str_cmp} <= c;
    @(negedge sys_clk);
    foreach (bq[i]) fm.send(bq[i]);
    repeat (hold) @(posedge sys_clk);
    if (hold != 0) begin
      `CK("frozen", 1'b0, decode_valid)
      clk_en <= 1'b1;
    end
    for (int k = 0; k < 60; k++) begin
      @(posedge sys_clk);
      if (decode_valid === 1'b1) return;
    end
    bad_count++;
    $display("unexpected decode_valid exp 1 got 0");
    test_done();
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    hold = 0;
    {op_need_modrm, op_need_imm, op_has_sext, op_is_shift, op_is_str_cmp,
     repeat_match_bit} = 6'h00;
    {base_word_reg, base_pointer} = {16'hf000, 16'h8000};
    {source_index, dest_index} = {16'h1111, 16'h2222};
    count_low_byte = 8'h00;
    {overflow_flag, direction_flag, int_enable_flag, trap_flag, sign_flag,
     zero_flag, aux_carry_flag, parity_flag, carry_flag} = 9'h000;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    `CK("ready", 1'b0, byte_ready)
    rst <= 1'b0;
    // Walk case, frozen by clock enable first; the sum wraps
    clk_en <= 1'b0;
    hold = 6;
    bq = '{8'h03, 8'h40, 8'hfe};
    run(5'h10);
    hold = 0;
    `CK("offset", 16'hfffe, offset_value)
    `CK("ea", 16'h010f, effective_address)
    `CK("dir", 1'b1, to_reg_dest)
    `CK("word", 1'b1, word_op)
    `CK("reg", OAD_R_ACCUM_W, reg_operand)
    $display("test walk done");
    // Every select code with a word displacement, slow fetch
    fm.slow <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      bq = '{8'h00, {2'b10, r[2:0], r[2:0]}, 8'h34, 8'h12};
      run(5'h10);
      `CK("ea", ea_of(r[2:0], 16'h1234), effective_address)
      `CK("reg", oad_gpr_t'(4'h8 + r[3:0]), reg_operand)
      `CK("dir", 1'b0, to_reg_dest)
    end
    // Register form
    for (int r = 0; r < 8; r++) begin
      bq = '{8'h01, {2'b11, r[2:0], ~r[2:0]}};
      run(5'h10);
      `CK("rm_is_reg", 1'b1, rm_is_reg)
      `CK("reg", oad_gpr_t'(r[3:0]), reg_operand)
      `CK("rm", oad_gpr_t'({1'b0, ~r[2:0]}), rm_operand)
    end
    fm.slow <= 1'b0;
    $display("test select codes done");
    // Direct address then plain form, back to back
    bq = '{8'h8b, 8'h06, 8'h34, 8'h12, 8'h8b, 8'h07};
    run(5'h10);
    `CK("ea", 16'h1234, effective_address)
    bq.delete();
    run(5'h10);
    `CK("offset", OAD_ZERO_WORD, offset_value)
    `CK("ea", 16'hf000, effective_address)
    // Immediates, one after a displacement
    bq = '{8'h81, 8'hc0, 8'h34, 8'h12};
    run(5'h1c);
    `CK("imm", 16'h1234, imm_operand)
    bq = '{8'h83, 8'h47, 8'h05, 8'h80};
    run(5'h1c);
    `CK("imm", 16'hff80, imm_operand)
    `CK("offset", 16'h0005, offset_value)
    `CK("ea", 16'hf005, effective_address)
    // Shift count source
    count_low_byte <= 8'h07;
    bq = '{8'hd0, 8'he0};
    run(5'h12);
    `CK("count", OAD_SHIFT_ONE, shift_count)
    bq = '{8'hd2, 8'he0};
    run(5'h12);
    `CK("count", 8'h07, shift_count)
    $display("test operands done");
    // Repeat decision for every match bit and zero flag pair
    for (int m = 0; m < 4; m++) begin
      {repeat_match_bit, zero_flag} <= m[1:0];
      bq = '{8'ha6};
      run(5'h01);
      `CK("rep", m[1] ~^ m[0], rep_continue)
    end
    // Each segment prefix, then none
    for (int s = 0; s < 4; s++) begin
      bq = '{{OAD_PFX_HI, s[1:0], OAD_PFX_LO}, 8'h90};
      run(5'h00);
      `CK("seg_ovr", 1'b1, seg_override)
      `CK("seg", oad_seg_t'(s[1:0]), seg_select)
    end
    bq = '{8'h90};
    run(5'h00);
    `CK("seg_ovr", 1'b0, seg_override)
    // Flag word packing and conditions over a table of patterns
    for (int p = 0; p < 4; p++) begin
      {overflow_flag, direction_flag, int_enable_flag, trap_flag, sign_flag,
       zero_flag, aux_carry_flag, parity_flag, carry_flag} <= FP[p];
      f = FP[p];
      run(5'h00);
      `CK("flags", {4'h0, f[8:3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]},
          flags_word)
      `CK("below", f[0], cond_below)
      `CK("above", ~f[0] & ~f[3], cond_above)
      `CK("less", f[4] ^ f[8], cond_less)
      `CK("greater", ~f[3] & ~(f[4] ^ f[8]), cond_greater)
    end
    $display("test flags done");
    test_done();
  end
endmodule // tb
`default_nettype wire
